// [inc/gfm_pkg.sv]
// constants, types and function tables for the pin 4 to 7 function selector
//
// Functional notes
// - start-up flag hands pin 4 to detection
// - no override, enable low: pin high-impedance, readable
// - pin 4 mode table, code 101 not inverted
// - pins usable as converter inputs via channel field
// - pin 4 is open drain, pulls low only
// - master role gives pin 5 slave control
// - external system loop 1 drives pin 5
// - pin 5 mode table, upper codes inverted
// - pin 5 push-pull, drives both levels
// - standby or switch 1 enable owns pin 6
// - switch 1 enable forces pin 6 enable low
// - pin 6 mode table
// - pins 6 and 7 push-pull outputs
// - switch 2 enable owns pin 7, forces enable low
// - pin 7 mode table
package gfm_pkg;

	// apb register byte offsets
	localparam logic [7:0] OUT_ENABLE_OFS  = 8'h00;
	localparam logic [7:0] OUT_DATA_OFS    = 8'h04;
	localparam logic [7:0] MODE_OFS        = 8'h08;
	localparam logic [7:0] CONVERTER_OFS   = 8'h0C;
	localparam logic [7:0] PIN_STATUS_OFS  = 8'h10;

	// field positions
	localparam int        MODE_W          = 3;
	localparam int        CHAN_W          = 5;
	localparam int        CONV_START_BIT  = 8;
	localparam int        STAT_OE_LSB     = 4;
	localparam int        STAT_SW_LSB     = 8;
	localparam int        STAT_START_BIT  = 10;

	// reset values
	localparam logic [3:0]  OUT_ENABLE_RST = 4'h0;
	localparam logic [3:0]  OUT_DATA_RST   = 4'h0;
	localparam logic [11:0] MODE_RST       = 12'h000;
	localparam logic [4:0]  CHAN_RST       = 5'h00;

	// per-code source index (two bits per code, code 0 lowest), inversion and disable masks
	localparam logic [15:0] PIN4_SEL = 16'hE4E4;
	localparam logic [7:0]  PIN4_INV = 8'hD0;
	localparam logic [7:0]  PIN4_OFF = 8'h00;
	localparam logic [15:0] PIN5_SEL = 16'hE4E4;
	localparam logic [7:0]  PIN5_INV = 8'hF0;
	localparam logic [7:0]  PIN5_OFF = 8'h00;
	localparam logic [15:0] PIN67_SEL = 16'hC9E4;
	localparam logic [7:0]  PIN67_INV = 8'hB0;
	localparam logic [7:0]  PIN67_OFF = 8'h40;

	// override conditions from the rest of the device
	typedef struct packed {
		logic       startupActive;
		logic       masterRole;
		logic       lowPowerStandby;
		logic       loopOneSystemFlag;
		logic       loopOneBridge3SideA;
		logic       loopOneBridge3SideB;
		logic [1:0] lowVoltageSwitchEnable;
	} gfm_ovr_s;

	// function sources from the rest of the device
	typedef struct packed {
		logic interruptOut;
		logic auxPwmOne;
		logic auxPwmTwo;
		logic auxPwmThree;
		logic comparatorOneOutput;
		logic comparatorTwoOutput;
		logic regulatorLoopOneOutput;
		logic converterEventOutput;
		logic slaveControl;
	} gfm_src_s;

endpackage

// [logic/gfm_mode_mux.sv]
// mode-code decoder for one pin: source pick, inversion and disable
`timescale 1ns/1ps
module gfm_mode_mux #(
	parameter logic [15:0] SEL = 16'hE4E4,
	parameter logic [7:0]  INV = 8'h00,
	parameter logic [7:0]  OFF = 8'h00
) (
	// selection
	input  wire logic [3:0] sources,
	input  wire logic [2:0] mode,
	// result
	output logic            level,
	output logic            drive
);

	logic [1:0] pick;

	always_comb
	begin
		pick  = SEL[{mode, 1'b0} +: 2];
		level = sources[pick] ^ INV[mode];
		drive = ~OFF[mode];
	end

endmodule

// [logic/gfm_pin_function_mux.sv]
// function selection for pins 4 to 7 with apb register access
`timescale 1ns/1ps
module gfm_pin_function_mux (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic      [31:0]       prdata,
	output logic                   pslverr,
	// device state and sources
	input  wire gfm_pkg::gfm_ovr_s sysOvr,
	input  wire gfm_pkg::gfm_src_s funcSrc,
	// pins, index 0 is pin 4
	input  wire logic [3:0]        pinIn,
	output logic      [3:0]        pinOut,
	output logic      [3:0]        pinOe,
	// to other units
	output logic                   startupDetectLevel,
	output logic      [1:0]        lowVoltageSwitchOn,
	output logic      [4:0]        converterChannelSelect,
	output logic                   converterStart
);

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic [3:0]  pinOutputEnableReg;
	logic [3:0]  outDataReg;
	logic [11:0] modeReg;
	logic [3:0]  pinLevel;
	logic [3:0]  muxLevel;
	logic [3:0]  muxDrive;
	logic [3:0]  pinOutNext;
	logic [3:0]  pinOeNext;
	logic [1:0]  switchOnNext;
	logic        loopExternal;
	logic        wrStrobe;
	logic [31:0] rdNext;
	logic        addrHit;

	////////////////////////////////////////////////////////////////
	// apb slave: one wait-free access cycle

	assign wrStrobe = psel & penable & pwrite & pready;

	always_comb
	begin
		addrHit = 1'b1;
		rdNext  = 32'h0000_0000;
		case (paddr)
			gfm_pkg::OUT_ENABLE_OFS: rdNext[3:0] = pinOutputEnableReg;
			gfm_pkg::OUT_DATA_OFS:   rdNext[3:0] = outDataReg;
			gfm_pkg::MODE_OFS:       rdNext[11:0] = modeReg;
			gfm_pkg::CONVERTER_OFS:  rdNext[gfm_pkg::CHAN_W-1:0] = converterChannelSelect;
			gfm_pkg::PIN_STATUS_OFS:
			begin
				rdNext[3:0] = pinLevel;
				rdNext[gfm_pkg::STAT_OE_LSB +: 4] = pinOe;
				rdNext[gfm_pkg::STAT_SW_LSB +: 2] = lowVoltageSwitchOn;
				rdNext[gfm_pkg::STAT_START_BIT] = sysOvr.startupActive;
			end
			default: addrHit = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~addrHit;
			if (psel & ~penable & ~pwrite)
			begin
				prdata <= rdNext;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pinOutputEnableReg <= gfm_pkg::OUT_ENABLE_RST;
		end
		else
		begin
			if (wrStrobe && paddr == gfm_pkg::OUT_ENABLE_OFS)
			begin
				pinOutputEnableReg <= pwdata[3:0];
			end
			if (sysOvr.lowVoltageSwitchEnable[0])
			begin
				pinOutputEnableReg[2] <= 1'b0;
			end
			if (sysOvr.lowVoltageSwitchEnable[1])
			begin
				pinOutputEnableReg[3] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			outDataReg <= gfm_pkg::OUT_DATA_RST;
			modeReg    <= gfm_pkg::MODE_RST;
		end
		else
		begin
			if (wrStrobe && paddr == gfm_pkg::OUT_DATA_OFS)
			begin
				outDataReg <= pwdata[3:0];
			end
			if (wrStrobe && paddr == gfm_pkg::MODE_OFS)
			begin
				modeReg <= pwdata[11:0];
			end
		end
	end

	// converter channel and one-cycle start pulse
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			converterChannelSelect <= gfm_pkg::CHAN_RST;
			converterStart         <= 1'b0;
		end
		else
		begin
			converterStart <= 1'b0;
			if (wrStrobe && paddr == gfm_pkg::CONVERTER_OFS)
			begin
				converterChannelSelect <= pwdata[gfm_pkg::CHAN_W-1:0];
				converterStart         <= pwdata[gfm_pkg::CONV_START_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// pin level capture and mode decoders

	gfm_sync2 #(
		.W (4)
	) u_pin_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.asyncIn (pinIn),
		.syncOut (pinLevel)
	);

	gfm_mode_mux #(
		.SEL (gfm_pkg::PIN4_SEL),
		.INV (gfm_pkg::PIN4_INV),
		.OFF (gfm_pkg::PIN4_OFF)
	) u_mux4 (
		.sources ({funcSrc.auxPwmThree, funcSrc.auxPwmOne, funcSrc.interruptOut, outDataReg[0]}),
		.mode    (modeReg[2:0]),
		.level   (muxLevel[0]),
		.drive   (muxDrive[0])
	);

	gfm_mode_mux #(
		.SEL (gfm_pkg::PIN5_SEL),
		.INV (gfm_pkg::PIN5_INV),
		.OFF (gfm_pkg::PIN5_OFF)
	) u_mux5 (
		.sources ({funcSrc.auxPwmThree, funcSrc.regulatorLoopOneOutput, funcSrc.comparatorOneOutput,
			outDataReg[1]}),
		.mode    (modeReg[5:3]),
		.level   (muxLevel[1]),
		.drive   (muxDrive[1])
	);

	gfm_mode_mux #(
		.SEL (gfm_pkg::PIN67_SEL),
		.INV (gfm_pkg::PIN67_INV),
		.OFF (gfm_pkg::PIN67_OFF)
	) u_mux6 (
		.sources ({funcSrc.comparatorTwoOutput, funcSrc.auxPwmTwo, funcSrc.converterEventOutput,
			outDataReg[2]}),
		.mode    (modeReg[8:6]),
		.level   (muxLevel[2]),
		.drive   (muxDrive[2])
	);

	gfm_mode_mux #(
		.SEL (gfm_pkg::PIN67_SEL),
		.INV (gfm_pkg::PIN67_INV),
		.OFF (gfm_pkg::PIN67_OFF)
	) u_mux7 (
		.sources ({funcSrc.comparatorOneOutput, funcSrc.auxPwmThree, funcSrc.auxPwmOne, outDataReg[3]}),
		.mode    (modeReg[11:9]),
		.level   (muxLevel[3]),
		.drive   (muxDrive[3])
	);

	////////////////////////////////////////////////////////////////
	// priority of overrides over the mode tables

	assign loopExternal = sysOvr.loopOneSystemFlag & ~sysOvr.loopOneBridge3SideA & ~sysOvr.loopOneBridge3SideB;

	always_comb
	begin
		pinOutNext   = 4'h0;
		pinOeNext    = 4'h0;
		switchOnNext = 2'h0;
		// pin 4: open drain, output level is always low
		if (sysOvr.startupActive)
		begin
			pinOeNext[0] = 1'b0;
		end
		else if (pinOutputEnableReg[0] & muxDrive[0])
		begin
			pinOeNext[0] = ~muxLevel[0];
		end
		// pin 5: push-pull
		if (sysOvr.masterRole)
		begin
			pinOutNext[1] = funcSrc.slaveControl;
			pinOeNext[1]  = 1'b1;
		end
		else if (loopExternal)
		begin
			pinOutNext[1] = funcSrc.regulatorLoopOneOutput;
			pinOeNext[1]  = 1'b1;
		end
		else if (pinOutputEnableReg[1] & muxDrive[1])
		begin
			pinOutNext[1] = muxLevel[1];
			pinOeNext[1]  = 1'b1;
		end
		// pin 6: push-pull
		if (sysOvr.lowPowerStandby | sysOvr.lowVoltageSwitchEnable[0])
		begin
			switchOnNext[0] = 1'b1;
		end
		else if (pinOutputEnableReg[2] & muxDrive[2])
		begin
			pinOutNext[2] = muxLevel[2];
			pinOeNext[2]  = 1'b1;
		end
		// pin 7: push-pull
		if (sysOvr.lowVoltageSwitchEnable[1])
		begin
			switchOnNext[1] = 1'b1;
		end
		else if (pinOutputEnableReg[3] & muxDrive[3])
		begin
			pinOutNext[3] = muxLevel[3];
			pinOeNext[3]  = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pinOut             <= 4'h0;
			pinOe              <= 4'h0;
			lowVoltageSwitchOn <= 2'h0;
			startupDetectLevel <= 1'b0;
		end
		else
		begin
			pinOut             <= pinOutNext;
			pinOe              <= pinOeNext;
			lowVoltageSwitchOn <= switchOnNext;
			startupDetectLevel <= sysOvr.startupActive & pinLevel[0];
		end
	end

	////////////////////////////////////////////////////////////////
	// checks

	AST_STARTUP_HIZ: assert property (sysOvr.startupActive |=> !pinOe[0])
		else $error("pin 4 driven during start-up detection");

	AST_DISABLED_HIZ: assert property (!sysOvr.lowVoltageSwitchEnable[1] && !pinOutputEnableReg[3] |=> !pinOe[3])
		else $error("pin 7 driven with enable low");

	AST_PIN4_CODE5: assert property (!sysOvr.startupActive && pinOutputEnableReg[0] && modeReg[2:0] == 3'h5
		|=> pinOe[0] == !$past(funcSrc.interruptOut))
		else $error("pin 4 code 101 wrong level");

	AST_CONV_PULSE: assert property (wrStrobe && paddr == gfm_pkg::CONVERTER_OFS && pwdata[gfm_pkg::CONV_START_BIT]
		|=> converterStart ##1 !converterStart)
		else $error("converter start not a single pulse");

	AST_OPEN_DRAIN: assert property (!sysOvr.startupActive && pinOutputEnableReg[0] && modeReg[2:0] == 3'h0
		|=> !pinOut[0] && pinOe[0] == !$past(outDataReg[0]))
		else $error("pin 4 not open drain on data bit");

	AST_MASTER: assert property (sysOvr.masterRole |=> pinOe[1] && pinOut[1] == $past(funcSrc.slaveControl))
		else $error("pin 5 not slave control in master role");

	AST_LOOP_EXT: assert property (!sysOvr.masterRole && loopExternal
		|=> pinOe[1] && pinOut[1] == $past(funcSrc.regulatorLoopOneOutput))
		else $error("pin 5 not regulation loop output");

	AST_PIN5_INV: assert property (!sysOvr.masterRole && !loopExternal && pinOutputEnableReg[1] && modeReg[5:3] == 3'h4
		|=> pinOe[1] && pinOut[1] == !$past(outDataReg[1]))
		else $error("pin 5 code 100 not inverted data");

	AST_PUSH_PULL: assert property (!sysOvr.masterRole && !loopExternal && pinOutputEnableReg[1] && modeReg[5:3] == 3'h0
		|=> pinOe[1] && pinOut[1] == $past(outDataReg[1]))
		else $error("pin 5 not driven from data bit");

	AST_SWITCH1: assert property (sysOvr.lowPowerStandby || sysOvr.lowVoltageSwitchEnable[0]
		|=> lowVoltageSwitchOn[0] && !pinOe[2])
		else $error("pin 6 not given to switch 1");

	AST_SWITCH1_OE: assert property (sysOvr.lowVoltageSwitchEnable[0] |=> !pinOutputEnableReg[2])
		else $error("pin 6 enable not forced low");

	AST_PIN6_EVT: assert property (!sysOvr.lowPowerStandby && !sysOvr.lowVoltageSwitchEnable[0]
		&& pinOutputEnableReg[2] && modeReg[8:6] == 3'h1
		|=> pinOe[2] && pinOut[2] == $past(funcSrc.converterEventOutput))
		else $error("pin 6 code 001 wrong");

	AST_SWITCH2: assert property (sysOvr.lowVoltageSwitchEnable[1]
		|=> lowVoltageSwitchOn[1] && !pinOe[3] && !pinOutputEnableReg[3])
		else $error("pin 7 not given to switch 2");

	AST_PIN7_COMP: assert property (!sysOvr.lowVoltageSwitchEnable[1] && pinOutputEnableReg[3] && modeReg[11:9] == 3'h7
		|=> pinOe[3] && pinOut[3] == !$past(funcSrc.comparatorOneOutput))
		else $error("pin 7 code 111 wrong");

	AST_CODE6_OFF: assert property (!sysOvr.lowPowerStandby && !sysOvr.lowVoltageSwitchEnable[0]
		&& modeReg[8:6] == 3'h6 |=> !pinOe[2])
		else $error("pin 6 code 110 driven");

endmodule

// [logic/gfm_sync2.sv]
// two-stage synchroniser for pin levels
`timescale 1ns/1ps
module gfm_sync2 #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// data
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);

	logic [W-1:0] stageOneReg;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stageOneReg <= '0;
			syncOut     <= '0;
		end
		else
		begin
			stageOneReg <= asyncIn;
			syncOut     <= stageOneReg;
		end
	end

endmodule

// [verification/gfm_pad_model.sv]
// board pads around pins 4 to 7: resolves the level seen at each pad
`timescale 1ns/1ps
module gfm_pad_model (
	// from the selector
	input  wire logic [3:0] pinOut,
	input  wire logic [3:0] pinOe,
	// board side level when a pad is released
	input  wire logic [3:0] extLevel,
	// to the selector
	output logic      [3:0] pinIn
);
	////////////////////////////////////////////////////////////////
	// pin 4 only ever pulls low, else the board level shows
	assign pinIn[0] = pinOe[0] ? 1'b0 : extLevel[0];
	// push-pull pads follow the driver while enabled
	assign pinIn[3:1] = (pinOe[3:1] & pinOut[3:1]) | (~pinOe[3:1] & extLevel[3:1]);
endmodule

// [verification/testbench.sv]
// self-checking bench for the pin 4 to 7 function selector
`timescale 1ns/1ps
module testbench;
	logic              clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h00000000;
	logic              pready;
	logic [31:0]       prdata;
	logic              pslverr;
	gfm_pkg::gfm_ovr_s ovr = 8'h00;
	gfm_pkg::gfm_src_s src = 9'h000;
	logic [3:0]        extLevel = 4'hF;
	logic [3:0]        pinIn;
	logic [3:0]        pinOut;
	logic [3:0]        pinOe;
	logic              startupDetectLevel;
	logic [1:0]        lowVoltageSwitchOn;
	logic [4:0]        converterChannelSelect;
	logic              converterStart;
	int                errors = 0;
	int                total_checks = 0;
	int                seed = 32'h2793;
	int                cnt;
	logic [31:0]       rd;
	logic [31:0]       r;
	logic              err;
	logic [3:0]        en;
	logic [3:0]        dat;
	logic [3:0]        expOe;
	logic [3:0]        expOut;
	logic [3:0]        pad;
	logic [11:0]       mode;

	always #12.5 clk = ~clk;

	gfm_pin_function_mux dut_u (
		.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.sysOvr(ovr), .funcSrc(src), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.startupDetectLevel(startupDetectLevel), .lowVoltageSwitchOn(lowVoltageSwitchOn),
		.converterChannelSelect(converterChannelSelect), .converterStart(converterStart)
	);

	gfm_pad_model pad_u (
		.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn)
	);

	////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer; holds the request until pready is seen high or 20 cycles have passed
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		chk(n < 20, 1'b1, "apb answer");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// expected drive of each pin from registers, overrides and sources
	function automatic void expPins();
		logic [7:0] lv4;
		logic [7:0] lv5;
		logic [7:0] lv6;
		logic [7:0] lv7;
		lv4 = {~src.auxPwmThree, ~src.auxPwmOne, src.interruptOut, ~dat[0],
			src.auxPwmThree, src.auxPwmOne, src.interruptOut, dat[0]};
		lv5 = {~src.auxPwmThree, ~src.regulatorLoopOneOutput, ~src.comparatorOneOutput, ~dat[1],
			src.auxPwmThree, src.regulatorLoopOneOutput, src.comparatorOneOutput, dat[1]};
		lv6 = {~src.comparatorTwoOutput, 1'b0, ~src.auxPwmTwo, ~src.converterEventOutput,
			src.comparatorTwoOutput, src.auxPwmTwo, src.converterEventOutput, dat[2]};
		lv7 = {~src.comparatorOneOutput, 1'b0, ~src.auxPwmThree, ~src.auxPwmOne,
			src.comparatorOneOutput, src.auxPwmThree, src.auxPwmOne, dat[3]};
		expOe = 4'h0;
		expOut = 4'h0;
		expOe[0] = !ovr.startupActive && en[0] && !lv4[mode[2:0]];
		if (ovr.masterRole)
			{expOe[1], expOut[1]} = {1'b1, src.slaveControl};
		else if (ovr.loopOneSystemFlag && !ovr.loopOneBridge3SideA && !ovr.loopOneBridge3SideB)
			{expOe[1], expOut[1]} = {1'b1, src.regulatorLoopOneOutput};
		else if (en[1])
			{expOe[1], expOut[1]} = {1'b1, lv5[mode[5:3]]};
		if (!ovr.lowPowerStandby && !ovr.lowVoltageSwitchEnable[0] && en[2] && mode[8:6] != 3'h6)
			{expOe[2], expOut[2]} = {1'b1, lv6[mode[8:6]]};
		if (!ovr.lowVoltageSwitchEnable[1] && en[3] && mode[11:9] != 3'h6)
			{expOe[3], expOut[3]} = {1'b1, lv7[mode[11:9]]};
		pad = (expOe & expOut) | (~expOe & extLevel);
	endfunction

	////////////////////////////////////////////////////////////////
	initial
	begin
		#2000000;
		errors++;
		summarize();
	end

	initial
	begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 16; a += 4)
		begin
			apb(1'b0, 8'(a), 32'h00000000);
			chk(rd, 32'h00000000, "reset value");
		end
		apb(1'b1, 8'h14, 32'hFFFFFFFF);
		chk(err, 1'b1, "unmapped write");
		apb(1'b0, 8'h14, 32'h00000000);
		chk(err, 1'b1, "unmapped read error");
		chk(rd, 32'h00000000, "unmapped read data");
		// converter channel and start pulse
		for (int i = 0; i < 4; i++)
		begin
			r = $random(seed);
			apb(1'b1, gfm_pkg::CONVERTER_OFS, {23'h000000, 1'b1, 3'h0, r[4:0]});
			cnt = 0;
			repeat (3)
			begin
				#1 cnt += converterStart;
				@(posedge clk);
			end
			chk(cnt, 1, "start pulse count");
			chk(converterChannelSelect, r[4:0], "channel out");
			apb(1'b0, gfm_pkg::CONVERTER_OFS, 32'h00000000);
			chk(rd, {27'h0000000, r[4:0]}, "channel readback");
		end
		// random configurations; odd rounds keep only the loop 1 override flags and are fully enabled
		for (int k = 0; k < 200; k++)
		begin
			r = $random(seed);
			@(posedge clk);
			ovr <= k[0] ? (r[7:0] & 8'h1C) : r[7:0];
			src <= r[16:8];
			extLevel <= r[20:17];
			en = k[0] ? 4'hF : r[24:21];
			dat = r[28:25];
			r = $random(seed);
			mode = r[11:0];
			apb(1'b1, gfm_pkg::OUT_ENABLE_OFS, {28'h0000000, en});
			apb(1'b1, gfm_pkg::OUT_DATA_OFS, {28'h0000000, dat});
			apb(1'b1, gfm_pkg::MODE_OFS, {20'h00000, mode});
			repeat (4) @(posedge clk);
			#1;
			en = en & ~{ovr.lowVoltageSwitchEnable, 2'b00};
			expPins();
			chk(pinOe, expOe, "pin enables");
			chk(pinOut & (expOe | 4'h1), expOut, "pin levels");
			chk(startupDetectLevel, ovr.startupActive & pad[0], "startup level");
			chk(lowVoltageSwitchOn, {ovr.lowVoltageSwitchEnable[1],
				ovr.lowPowerStandby | ovr.lowVoltageSwitchEnable[0]}, "switch on");
			apb(1'b0, gfm_pkg::OUT_ENABLE_OFS, 32'h00000000);
			chk(rd, {28'h0000000, en}, "enable readback");
			apb(1'b0, gfm_pkg::PIN_STATUS_OFS, 32'h00000000);
			chk(rd, {21'h000000, ovr.startupActive, ovr.lowVoltageSwitchEnable[1],
				ovr.lowPowerStandby | ovr.lowVoltageSwitchEnable[0], expOe, pad}, "status");
			chk(err, 1'b0, "mapped access error");
		end
		// reset in mid-run: registers and pins back to idle
		@(posedge clk);
		ovr <= 8'h00;
		src <= 9'h000;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 16; a += 4)
		begin
			apb(1'b0, 8'(a), 32'h00000000);
			chk(rd, 32'h00000000, "value after reset");
		end
		chk({pinOe, pinOut, converterChannelSelect}, 13'h0000, "idle after reset");
		summarize();
	end
endmodule
